// File: verilog/dinr_pkg.sv
// Shared constants, types and reset values for the DAC serial target block
package dinr_pkg;

  // ==========================================================================
  // Widths and bit counts
  // ==========================================================================
  localparam int unsigned CODE_W = 12;         // DAC input code width
  localparam int unsigned PD_W   = 2;          // Power-down field width
  localparam logic [3:0] BIT_LAST_DATA = 4'h7; // Eighth data bit of a byte
  localparam logic [3:0] BIT_ACK_SLOT  = 4'h8; // Ninth clock, acknowledge

  // ==========================================================================
  // Byte codes and frame positions
  // ==========================================================================
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01; // Top of controller code
  localparam logic [2:0] CMD_WR_DAC     = 3'h2;  // Update DAC register only
  localparam logic [2:0] CMD_WR_DAC_NVM = 3'h3;  // Update DAC and NVM
  localparam logic [2:0] WR_LAST_IDX    = 3'h2;  // Third written byte
  localparam logic [2:0] RD_LAST_IDX    = 3'h4;  // Fifth read byte
  localparam logic [2:0] IDX_MAX        = 3'h7;  // Byte index saturates

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [CODE_W-1:0] NVM_CODE_RST = 12'h800; // Mid-scale
  localparam logic [PD_W-1:0]   NVM_PD_RST   = 2'h0;    // Normal output

  // ==========================================================================
  // Types
  // ==========================================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_BOOT   = 3'h0,
    ST_IDLE   = 3'h1,
    ST_ADDR   = 3'h2,
    ST_WRITE  = 3'h3,
    ST_READ   = 3'h4,
    ST_IGNORE = 3'h5
  } dinr_state_e;

  // Link-domain sample handed to the system domain
  typedef struct packed {
    logic toggle;   // Flips on every rising bus clock
    logic bit_val;  // Data line level at that edge
  } dinr_link_s;

  // Whole state of the system-clock side
  typedef struct packed {
    dinr_state_e       state;
    logic [3:0]        cnt;      // Rising edges seen in this byte
    logic [7:0]        shift;    // Received bits
    logic [2:0]        idx;      // Byte index within the transfer
    logic              rd;       // Direction bit of the address
    logic              ack_en;   // Acknowledge the current byte
    logic              oe;       // Pulling the data line low
    logic              hs;       // High-speed operation active
    logic [2:0]        cmd;      // Command of the write transfer
    logic [PD_W-1:0]   pd_wr;    // Power-down bits being written
    logic [CODE_W-1:0] code_wr;  // Code being written
    logic [CODE_W-1:0] dac_code; // DAC register
    logic [PD_W-1:0]   dac_pd;
    logic [CODE_W-1:0] nvm_code; // Non-volatile copy
    logic [PD_W-1:0]   nvm_pd;
    logic              scl_hold; // Clock line pull, zero from reset and never set
    logic              drive_lvl;// Level put on a driven line
    logic [2:0]        scl_s;    // Clock pin synchroniser and history
    logic [2:0]        sda_s;    // Data pin synchroniser and history
    logic [1:0]        sel_s;    // Address pin synchroniser
    logic [2:0]        tgl_s;    // Link toggle synchroniser and history
  } dinr_st_s;

  localparam dinr_st_s ST_RESET = '{
    state: ST_BOOT, cnt: 4'h0, shift: 8'h00, idx: 3'h0, rd: 1'b0,
    ack_en: 1'b0, oe: 1'b0, hs: 1'b0, cmd: 3'h0, pd_wr: 2'h0,
    code_wr: 12'h000, dac_code: 12'h000, dac_pd: 2'h0,
    nvm_code: NVM_CODE_RST, nvm_pd: NVM_PD_RST, scl_hold: 1'b0,
    drive_lvl: 1'b0, scl_s: 3'h7, sda_s: 3'h7, sel_s: 2'h0, tgl_s: 3'h0};

endpackage : dinr_pkg

// File: verilog/dinr_link_sampler.sv
// Bus-clock domain sampler of the data line
`timescale 1ns/100ps
module dinr_link_sampler (
  // Bus clock and reset
  input  wire logic               scl_clk_in,
  input  wire logic               rst_n_in,
  // Bus data line level
  input  wire logic               sda_in,
  // Sample to the system domain
  output dinr_pkg::dinr_link_s    link_out
);
  import dinr_pkg::*;

  // ==========================================================================
  // Sample register
  // ==========================================================================
  dinr_link_s st_reg;   // Held stable for a whole bus clock period
  dinr_link_s st_next;

  // Sample data on each rising bus clock, flip the event toggle
  always_comb begin
    st_next         = st_reg;
    st_next.bit_val = sda_in;
    st_next.toggle  = ~st_reg.toggle;
  end

  // The bus clock may stop between frames; nothing here waits on it
  always_ff @(posedge scl_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link_out = st_reg;

endmodule : dinr_link_sampler

// File: verilog/dinr_top.sv
// Serial target, power-up restore and NVM of a 12-bit DAC
`timescale 1ns/100ps

// Contract
// - Acknowledge own address for read or write
// - Pull data low during acknowledge clock
// - Release data line after acknowledge clock
// - Accept STOP or repeated START afterwards
// - Write command stores code and power-down
// - Read command returns non-volatile contents
// - Power-up copies NVM into DAC register
// - Address low bit from select pin
// - Lines are only pulled low or released
// - Ignore high-speed code, leave at STOP
module dinr_top #(
  parameter logic [5:0] ADDR_HI = 6'h30  // Upper six address bits
) (
  // System clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  // Bus pins
  input  wire logic                         scl_clk_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_out,
  output logic                              scl_out,
  output logic                              scl_oe_out,
  // Address select pin
  input  wire logic                         address_low_bit_pin_in,
  // DAC register and mode
  output logic [dinr_pkg::CODE_W-1:0]       dac_code_out,
  output logic [dinr_pkg::PD_W-1:0]         dac_pd_out,
  output logic                              hs_mode_out
);
  import dinr_pkg::*;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_reg;   // Release synchroniser
  logic       rst_sync_n;     // Reset copy used everywhere else

  // Assert at once, release after two clock edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_reg[1];

  // ==========================================================================
  // Link domain
  // ==========================================================================
  dinr_link_s link;           // Bit sample and edge toggle

  dinr_link_sampler u_link (
    .scl_clk_in (scl_clk_in),
    .rst_n_in   (rst_sync_n),
    .sda_in     (sda_in),
    .link_out   (link)
  );

  // ==========================================================================
  // Protocol state
  // ==========================================================================
  dinr_st_s   st_reg;
  dinr_st_s   st_next;
  logic       scl_fall;       // Bus clock went low
  logic       start_evt;      // Data fell while clock high
  logic       stop_evt;       // Data rose while clock high
  logic       bit_evt;        // A rising bus clock was sampled
  logic [7:0] byte_in;        // Byte completed by the current bit
  logic [7:0] tx_byte;        // Byte being read out

  // Events use only the second and third synchroniser stages
  assign scl_fall  = st_reg.scl_s[2] & ~st_reg.scl_s[1];
  assign start_evt = st_reg.scl_s[2] & st_reg.scl_s[1] &
                     st_reg.sda_s[2] & ~st_reg.sda_s[1];
  assign stop_evt  = st_reg.scl_s[2] & st_reg.scl_s[1] &
                     ~st_reg.sda_s[2] & st_reg.sda_s[1];
  assign bit_evt   = st_reg.tgl_s[2] ^ st_reg.tgl_s[1];
  // Link bit is stable for a bus period, so the toggle qualifies it
  assign byte_in   = {st_reg.shift[6:0], link.bit_val};

  // Read-out sequence: status, DAC register, then the stored copy
  always_comb begin
    unique case (st_reg.idx)
      3'h0:    tx_byte = {2'h3, 3'h0, st_reg.dac_pd, 1'b0};
      3'h1:    tx_byte = st_reg.dac_code[11:4];
      3'h2:    tx_byte = {st_reg.dac_code[3:0], 4'h0};
      3'h3:    tx_byte = {1'b0, st_reg.nvm_pd, 1'b0,
                          st_reg.nvm_code[11:8]};
      default: tx_byte = st_reg.nvm_code[7:0];
    endcase
  end

  // Next-state logic for the whole system-clock side
  always_comb begin
    st_next       = st_reg;
    // Pin synchronisers: stage 0 is read only by stage 1
    st_next.scl_s = {st_reg.scl_s[1:0], scl_clk_in};
    st_next.sda_s = {st_reg.sda_s[1:0], sda_in};
    st_next.sel_s = {st_reg.sel_s[0], address_low_bit_pin_in};
    st_next.tgl_s = {st_reg.tgl_s[1:0], link.toggle};

    if (st_reg.state == ST_BOOT) begin
      // Restore the stored setting with no bus activity
      st_next.dac_code = st_reg.nvm_code;
      st_next.dac_pd   = st_reg.nvm_pd;
      st_next.state    = ST_IDLE;
    end else if (stop_evt) begin
      // Frame over: release, drop high speed
      st_next.state = ST_IDLE;
      st_next.oe    = 1'b0;
      st_next.hs    = 1'b0;
      st_next.cnt   = 4'h0;
    end else if (start_evt) begin
      // Fresh or repeated start restarts address capture
      st_next.state  = ST_ADDR;
      st_next.cnt    = 4'h0;
      st_next.oe     = 1'b0;
      st_next.ack_en = 1'b0;
      st_next.idx    = 3'h0;
    end else begin
      if (bit_evt && (st_reg.state == ST_ADDR ||
                      st_reg.state == ST_WRITE ||
                      st_reg.state == ST_READ)) begin
        if (st_reg.cnt != BIT_ACK_SLOT) begin
          // Data bit
          st_next.shift = byte_in;
          st_next.cnt   = st_reg.cnt + 4'h1;
          if (st_reg.cnt == BIT_LAST_DATA) begin
            unique case (st_reg.state)
              ST_ADDR: begin
                if (byte_in[7:3] == HS_CODE_PREFIX) begin
                  // Controller code: switch mode, never acknowledge
                  st_next.hs     = 1'b1;
                  st_next.ack_en = 1'b0;
                  st_next.state  = ST_IGNORE;
                end else if (byte_in[7:1] ==
                             {ADDR_HI, st_reg.sel_s[1]}) begin
                  st_next.ack_en = 1'b1;
                  st_next.rd     = byte_in[0];
                end else begin
                  // Someone else's address: stay off the line
                  st_next.ack_en = 1'b0;
                  st_next.state  = ST_IGNORE;
                end
              end
              ST_WRITE: begin
                st_next.ack_en = 1'b1;
                if (st_reg.idx == 3'h0) begin
                  st_next.cmd   = byte_in[7:5];
                  st_next.pd_wr = byte_in[2:1];
                end else if (st_reg.idx == 3'h1) begin
                  st_next.code_wr[11:4] = byte_in;
                end else if (st_reg.idx == WR_LAST_IDX) begin
                  st_next.code_wr[3:0] = byte_in[7:4];
                end
              end
              default: begin
                // Read byte sent; controller acknowledges
                st_next.ack_en = 1'b0;
              end
            endcase
          end
        end else begin
          // Acknowledge clock
          st_next.cnt = 4'h0;
          unique case (st_reg.state)
            ST_ADDR: begin
              st_next.state = st_reg.rd ? ST_READ : ST_WRITE;
              st_next.idx   = 3'h0;
            end
            ST_WRITE: begin
              if (st_reg.idx == WR_LAST_IDX) begin
                if (st_reg.cmd == CMD_WR_DAC ||
                    st_reg.cmd == CMD_WR_DAC_NVM) begin
                  st_next.dac_code = st_reg.code_wr;
                  st_next.dac_pd   = st_reg.pd_wr;
                end
                if (st_reg.cmd == CMD_WR_DAC_NVM) begin
                  st_next.nvm_code = st_reg.code_wr;
                  st_next.nvm_pd   = st_reg.pd_wr;
                end
              end
              if (st_reg.idx != IDX_MAX) begin
                st_next.idx = st_reg.idx + 3'h1;
              end
            end
            default: begin
              // Not acknowledged: controller is done reading
              if (link.bit_val) begin
                st_next.state = ST_IGNORE;
              end else if (st_reg.idx != RD_LAST_IDX) begin
                st_next.idx = st_reg.idx + 3'h1;
              end
            end
          endcase
        end
      end
      // Line changes only while the bus clock is low
      if (scl_fall) begin
        if (st_reg.cnt == BIT_ACK_SLOT && st_reg.ack_en &&
            (st_reg.state == ST_ADDR || st_reg.state == ST_WRITE)) begin
          st_next.oe = 1'b1;
        end else if (st_reg.state == ST_READ &&
                     st_reg.cnt != BIT_ACK_SLOT) begin
          // Open drain: a one is sent by letting go
          st_next.oe = ~tx_byte[~st_reg.cnt[2:0]];
        end else begin
          st_next.oe = 1'b0;
        end
      end
    end
  end

  // Single state register
  always_ff @(posedge clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs, all from the state register
  // ==========================================================================
  assign sda_out      = st_reg.drive_lvl;  // Only ever low
  assign sda_oe_out   = st_reg.oe;
  assign scl_out      = st_reg.drive_lvl;
  assign scl_oe_out   = st_reg.scl_hold;   // No clock stretching
  assign dac_code_out = st_reg.dac_code;
  assign dac_pd_out   = st_reg.dac_pd;
  assign hs_mode_out  = st_reg.hs;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_sync_n);

  // Eighth address bit matched, clock falls into the acknowledge slot
  sequence s_ack_slot;
    st_reg.state == ST_ADDR && st_reg.cnt == BIT_ACK_SLOT &&
    st_reg.ack_en && scl_fall && !start_evt && !stop_evt;
  endsequence
  // Acknowledge finished, clock falls after it in a write
  sequence s_ack_done;
    st_reg.state == ST_WRITE && st_reg.cnt == 4'h0 && st_reg.oe &&
    scl_fall && !start_evt && !stop_evt && !bit_evt;
  endsequence

  chk_ack_drive: assert property (
    s_ack_slot |=> sda_oe_out && !sda_out)
    else $error("acknowledge not driven low");
  chk_ack_release: assert property (
    s_ack_done |=> !sda_oe_out)
    else $error("data line held after acknowledge");
  chk_ack_match: assert property (
    (st_reg.state == ST_ADDR && st_reg.ack_en) |->
      st_reg.shift[7:1] == {ADDR_HI, st_reg.sel_s[1]})
    else $error("acknowledge without address match");
  chk_ignore_quiet: assert property (
    (st_reg.state == ST_IGNORE && $past(st_reg.state) == ST_IGNORE)
      |-> !sda_oe_out)
    else $error("data line driven while not addressed");
  chk_hs_exit: assert property (
    (stop_evt && st_reg.state != ST_BOOT) |=> !hs_mode_out ##1 !hs_mode_out)
    else $error("high speed kept after stop");
  chk_restart: assert property (
    (start_evt && !stop_evt && st_reg.state != ST_BOOT) |=>
      st_reg.state == ST_ADDR && st_reg.cnt == 4'h0 && !sda_oe_out)
    else $error("start not accepted");
  chk_boot_load: assert property (
    st_reg.state == ST_BOOT |=>
      dac_code_out == $past(st_reg.nvm_code) &&
      dac_pd_out == $past(st_reg.nvm_pd) && st_reg.state == ST_IDLE)
    else $error("power-up restore missing");
  chk_nvm_store: assert property (
    (bit_evt && st_reg.state == ST_WRITE && st_reg.cnt == BIT_ACK_SLOT &&
     st_reg.idx == WR_LAST_IDX && st_reg.cmd == CMD_WR_DAC_NVM &&
     !start_evt && !stop_evt) |=>
      st_reg.nvm_code == $past(st_reg.code_wr) &&
      st_reg.nvm_pd == $past(st_reg.pd_wr))
    else $error("NVM not written");
  chk_read_bit: assert property (
    (scl_fall && st_reg.state == ST_READ && st_reg.cnt != BIT_ACK_SLOT &&
     !start_evt && !stop_evt) |=>
      sda_oe_out == ~$past(tx_byte[~st_reg.cnt[2:0]]))
    else $error("read bit wrong");
  chk_open_drain: assert property (
    !scl_oe_out && !sda_out && !scl_out)
    else $error("line driven high");
endmodule : dinr_top

// File: sim/dinr_ctrl_model.sv
// Two-wire bus controller model that pulls clock and data lines low
`timescale 1ns/100ps
module dinr_ctrl_model (
  // Wired data level, high through the pull-up when released
  input  wire logic sda_line_in,
  // Pull-low requests of this controller
  output logic      scl_low_out,
  output logic      sda_low_out
);
  // ==========================================================================
  // Idle bus
  // ==========================================================================
  // Both lines released, so the clock stands still between frames
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // ==========================================================================
  // Bit level
  // ==========================================================================
  // One 125 ns bit: data changes while clock is low, sampled mid-high
  task automatic bit_cycle(input logic drv_low, output logic seen);
    #20 sda_low_out = drv_low;
    #42.5 scl_low_out = 1'b0;
    #31.2 seen = sda_line_in;
    #31.3 scl_low_out = 1'b1;
  endtask : bit_cycle

  // Start or repeated start, same shape from idle or from clock low
  task automatic start();
    #20 sda_low_out = 1'b0;
    #42.5 scl_low_out = 1'b0;
    #31.2 sda_low_out = 1'b1;    // Data falls while clock high
    #31.3 scl_low_out = 1'b1;
  endtask : start

  // Stop: data rises while clock high, then the bus rests idle
  task automatic stop();
    #20 sda_low_out = 1'b1;
    #42.5 scl_low_out = 1'b0;
    #31.2 sda_low_out = 1'b0;    // Transfer may end here
    #31.3;
  endtask : stop

  // ==========================================================================
  // Byte level
  // ==========================================================================
  // Eight data bits MSB first, then the ninth clock for the answer
  task automatic write_byte(input logic [7:0] b, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(~b[i], seen);
    end
    bit_cycle(1'b0, seen);
    acked = ~seen;
  endtask : write_byte

  // Data line released for eight bits; ack pulls low on the ninth
  task automatic read_byte(input logic ack, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, b[i]);
    end
    bit_cycle(ack, seen);
  endtask : read_byte
endmodule : dinr_ctrl_model

// File: sim/dac_i2c_presence_and_nvm_restore_test.sv
// Self-checking bench for the DAC serial target with a reference model
`timescale 1ns/100ps
module dac_i2c_presence_and_nvm_restore_test;
  import dinr_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam logic [5:0] ADDR_HI = 6'h30; // Upper address bits
  logic                  clk_in;          // 200 MHz system clock
  logic                  rst_n_in;        // Active-low reset
  logic                  addr_pin;        // Address select pin level
  logic                  m_scl_low;       // Controller pulls clock
  logic                  m_sda_low;       // Controller pulls data
  wire logic             scl_line;        // Wired clock line
  wire logic             sda_line;        // Wired data line
  logic                  sda_out;
  logic                  sda_oe_out;
  logic                  scl_out;
  logic                  scl_oe_out;
  logic [CODE_W-1:0]     dac_code_out;
  logic [PD_W-1:0]       dac_pd_out;
  logic                  hs_mode_out;
  int                    n_mismatch;      // Failed comparisons
  int                    comparisons;     // All comparisons
  int                    m_code;          // Reference DAC register
  int                    m_pd;
  int                    m_ncode;         // Reference non-volatile copy
  int                    m_npd;

  // Pull-ups: a line is low only while some party pulls it
  assign scl_line = ~(m_scl_low | (scl_oe_out & ~scl_out));
  assign sda_line = ~(m_sda_low | (sda_oe_out & ~sda_out));

  // ==========================================================================
  // Instances
  // ==========================================================================
  dinr_top #(.ADDR_HI(ADDR_HI)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .scl_clk_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .address_low_bit_pin_in(addr_pin),
    .dac_code_out(dac_code_out), .dac_pd_out(dac_pd_out),
    .hs_mode_out(hs_mode_out));

  dinr_ctrl_model ctrl_u (
    .sda_line_in(sda_line), .scl_low_out(m_scl_low),
    .sda_low_out(m_sda_low));

  // ==========================================================================
  // Compare and report
  // ==========================================================================
  task automatic cmp_val(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_ack(input string what, input logic exp,
                         input logic got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_ack

  // Single exit for the normal end and for the watchdog
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // Transfers
  // ==========================================================================
  // Start or repeated start, then the address byte
  task automatic addr(input logic pin, input logic rd, output logic ack);
    ctrl_u.start();
    ctrl_u.write_byte({ADDR_HI, pin, rd}, ack);
  endtask : addr

  // Let stop or start detection land, then compare register and pins
  task automatic check_dac();
    repeat (4) @(negedge clk_in);
    cmp_val("dac_code", 16'(m_code), {4'h0, dac_code_out});
    cmp_val("dac_pd", 16'(m_pd), {14'h0, dac_pd_out});
    cmp_ack("scl_oe", 1'b0, scl_oe_out);
    cmp_ack("sda_out", 1'b0, sda_out);
    cmp_ack("scl_out", 1'b0, scl_out);
  endtask : check_dac

  // Write of nb bytes; the model applies only whole known commands
  task automatic write_cmd(input logic [2:0] cmd, input logic [11:0] code,
                           input logic [1:0] pd, input int nb);
    logic       ack;
    logic [7:0] b [3];
    b[0] = {cmd, 2'b00, pd, 1'b0};
    b[1] = code[11:4];
    b[2] = {code[3:0], 4'h0};
    addr(addr_pin, 1'b0, ack);
    cmp_ack("write address ack", 1'b1, ack);
    for (int i = 0; i < nb; i++) begin
      ctrl_u.write_byte(b[i], ack);
      cmp_ack("data ack", 1'b1, ack);
    end
    if (nb == 3 && (cmd == CMD_WR_DAC || cmd == CMD_WR_DAC_NVM)) begin
      m_code = code;
      m_pd = pd;
      if (cmd == CMD_WR_DAC_NVM) begin
        m_ncode = code;
        m_npd = pd;
      end
    end
  endtask : write_cmd

  // Five-byte read, last byte refused by the controller
  task automatic read_back();
    logic       ack;
    logic [7:0] got;
    logic [7:0] exp [5];
    exp[0] = {2'b11, 3'b000, 2'(m_pd), 1'b0};
    exp[1] = 8'(m_code >> 4);
    exp[2] = {4'(m_code), 4'h0};
    exp[3] = {1'b0, 2'(m_npd), 1'b0, 4'(m_ncode >> 8)};
    exp[4] = 8'(m_ncode);
    addr(addr_pin, 1'b1, ack);
    cmp_ack("read address ack", 1'b1, ack);
    for (int i = 0; i < 5; i++) begin
      ctrl_u.read_byte(i < 4, got);
      cmp_val("read byte", {8'h00, exp[i]}, {8'h00, got});
    end
    ctrl_u.stop();
    check_dac();
    cmp_ack("released after read", 1'b0, sda_oe_out);
  endtask : read_back

  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Cuts a hang short; counts as a mismatch
  initial begin
    repeat (40000) @(posedge clk_in);
    n_mismatch++;
    conclude();
  end

  initial begin
    logic             ack;
    logic [2:0]       cmds [3];
    rst_n_in = 1'b0;
    addr_pin = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    m_code = 'h800;
    m_pd = 0;
    m_ncode = 'h800;
    m_npd = 0;
    cmds = '{CMD_WR_DAC, CMD_WR_DAC_NVM, 3'h5};
    void'($urandom(90));
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check_dac();
    // Presence check on both pin levels, foreign address refused
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      addr_pin <= p[0];
      repeat (6) @(posedge clk_in);
      addr(~addr_pin, 1'b1, ack);
      cmp_ack("foreign ack", 1'b0, ack);
      addr(addr_pin, 1'b1, ack);
      cmp_ack("presence ack", 1'b1, ack);
      ctrl_u.stop();
      check_dac();
      cmp_ack("released after ack", 1'b0, sda_oe_out);
      addr(addr_pin, 1'b0, ack);
      cmp_ack("presence write ack", 1'b1, ack);
      write_cmd(CMD_WR_DAC_NVM, 12'($urandom), 2'($urandom), 3);
      ctrl_u.stop();
      check_dac();
      read_back();
    end
    // Both write commands, plus one unknown command that must be ignored
    foreach (cmds[i]) begin
      write_cmd(cmds[i], 12'($urandom), 2'($urandom), 3);
      ctrl_u.stop();
      check_dac();
      read_back();
    end
    // Short write cut by repeated start applies nothing
    write_cmd(CMD_WR_DAC_NVM, 12'($urandom), 2'($urandom), 2);
    ctrl_u.start();
    ctrl_u.stop();
    check_dac();
    // High-speed code: refused, mode held until stop
    ctrl_u.start();
    ctrl_u.write_byte({HS_CODE_PREFIX, 3'($urandom)}, ack);
    cmp_ack("hs code ack", 1'b0, ack);
    repeat (4) @(negedge clk_in);
    cmp_ack("hs mode on", 1'b1, hs_mode_out);
    ctrl_u.stop();
    check_dac();
    cmp_ack("hs mode off", 1'b0, hs_mode_out);
    read_back();
    conclude();
  end
endmodule : dac_i2c_presence_and_nvm_restore_test
